// file: pkg/charger_port_mode_consts.svh
// Offsets, field positions, reset values and timing counts
`ifndef CHARGER_PORT_MODE_CONSTS_SVH
`define CHARGER_PORT_MODE_CONSTS_SVH
// ****************************************************
// Register offsets
// ****************************************************
`define OFS_MODE     8'h00
`define OFS_VLOW     8'h06
`define OFS_VHIGH    8'h07
`define OFS_GATE     8'h1C
`define OFS_CLKGATE  8'h27
`define OFS_ROLE     8'h28
`define OFS_LOOP     8'h2D
`define OFS_STANDBY  8'h2E
`define OFS_EVENT    8'h30
`define OFS_PRESENCE 8'h36
// ****************************************************
// Field positions
// ****************************************************
`define B_REVERSE    0
`define B_FBSEL      1
`define B_FORCE_DISCONTINUOUS       2
`define B_CCM        3
`define B_CONV_EN    4
`define B_LOAD       5
`define B_GATE_A     0
`define B_GATE_B     1
`define B_MON_EN     2
`define B_GATE_C1    3
`define B_GATE_C2    4
`define B_CLKDIS     0
`define B_PORTB_DIR  2
`define B_CC_LOOP    4
`define B_STANDBY    7
// ****************************************************
// Reset values
// ****************************************************
`define RST_MODE     8'h04
`define RST_VCODE    12'h916
`define RST_ZERO     8'h00
`define RST_I2C_ADDR 7'h2A
// ****************************************************
// Timing
// ****************************************************
`define CLK_KHZ        50000
`define SCAN_PERIOD_US 1000
`define SCAN_CYCLES    (`SCAN_PERIOD_US * `CLK_KHZ / 1000)
`define CORE_CLK_KHZ   8000
`define CORE_HALF_CYC  (`CLK_KHZ / (2 * `CORE_CLK_KHZ))
`endif

// file: pkg/charger_port_mode_pkg.sv
// Types shared by the charger port and mode control block
package charger_port_mode_pkg;
    typedef enum logic [2:0] {
        PM_SHUTDOWN = 3'b000,
        PM_STANDBY  = 3'b001,
        PM_NOCLOCK  = 3'b010,
        PM_NODCDC   = 3'b011,
        PM_NORMAL   = 3'b100
    } power_mode_t;
    typedef enum logic [1:0] {
        CM_AUTO = 2'b00,
        CM_PFM  = 2'b01,
        CM_CCM  = 2'b10,
        CM_DCM  = 2'b11
    } conduction_t;
    typedef enum logic [3:0] {
        I_IDLE  = 4'b0000,
        I_ADDR  = 4'b0001,
        I_AACK  = 4'b0010,
        I_REG   = 4'b0011,
        I_RACKW = 4'b0100,
        I_WDATA = 4'b0101,
        I_WACK  = 4'b0110,
        I_TX    = 4'b0111,
        I_TXACK = 4'b1000
    } i2c_state_t;
    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_wr_t;
    typedef struct packed {
        logic portALow;
        logic portBLow;
        logic portBSrc;
        logic c1Src;
        logic c2Src;
        logic smallCur;
        logic attached;
    } port_sense_t;
    typedef struct packed {
        logic c2;
        logic c1;
        logic b;
        logic a;
    } port_set_t;
endpackage : charger_port_mode_pkg

// file: core/charger_port_mode_control.sv
// Two-wire register bank, port control and power mode decode
`include "charger_port_mode_consts.svh"
module charger_port_mode_control
    import charger_port_mode_pkg::*;
#(
    parameter logic [6:0] I2C_ADDR    = `RST_I2C_ADDR, // Arbitrary value
    parameter int         SCAN_CYCLES = `SCAN_CYCLES,
    parameter int         CORE_HALF   = `CORE_HALF_CYC
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        sclIn,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe,
    input  wire port_sense_t senseIn,
    input  wire port_set_t   portFault,
    output logic             reverseOutputEnable,
    output logic             feedbackSourceSelect,
    output logic [11:0]      busVoltageCode,
    output logic             busCcLoopEnable,
    output conduction_t      conductionMode,
    output logic             portBDirection,
    output logic [1:0]       typecRoleField,
    output port_set_t        portGateDriver,
    output logic             analogMonitorEnable,
    output logic [3:0]       analogMonitorSelect,
    output power_mode_t      powerMode,
    output logic             converterRun,
    output logic             coreClkOut
);
    localparam int SW = $clog2(SCAN_CYCLES + 1);
    localparam int CW = $clog2(CORE_HALF + 1);
    if (SCAN_CYCLES < 2 || CORE_HALF < 1) begin : bad_params
        $error("Scan or core divider count too small");
    end

    // ****************************************************
    // Input synchronisers
    // ****************************************************
    logic        sclS1, sclS2, sclS3, sdaS1, sdaS2, sdaS3;
    port_sense_t senseS1, senseS2, senseScan;
    port_set_t   faultS1, faultS2;
    // Two flops on every outside level, third for edges
    always_ff @(posedge clk) begin
        if (!rstn) begin
            {sclS1, sclS2, sclS3} <= 3'h7;
            {sdaS1, sdaS2, sdaS3} <= 3'h7;
            senseS1 <= '0;
            senseS2 <= '0;
            faultS1 <= '0;
            faultS2 <= '0;
        end else begin
            {sclS1, sclS2, sclS3} <= {sclIn, sclS1, sclS2};
            {sdaS1, sdaS2, sdaS3} <= {sdaIn, sdaS1, sdaS2};
            senseS1 <= senseIn;
            senseS2 <= senseS1;
            faultS1 <= portFault;
            faultS2 <= faultS1;
        end
    end
    wire sclRise   = sclS2 & ~sclS3;
    wire sclFall   = ~sclS2 & sclS3;
    wire startCond = sclS2 & sclS3 & ~sdaS2 & sdaS3;
    wire stopCond  = sclS2 & sclS3 & sdaS2 & ~sdaS3;

    // ****************************************************
    // Slow scan tick
    // ****************************************************
    logic [SW-1:0] scanCnt;
    logic          scanTick;
    // One-millisecond pacing of port detection sampling
    always_ff @(posedge clk) begin
        if (!rstn) begin
            scanCnt   <= '0;
            scanTick  <= 1'b0;
            senseScan <= '0;
        end else begin
            scanTick <= (scanCnt == SW'(SCAN_CYCLES - 1));
            scanCnt  <= (scanCnt == SW'(SCAN_CYCLES - 1)) ? '0
                                                          : scanCnt + 1'b1;
            if (scanTick) begin
                senseScan <= senseS2;
            end
        end
    end

    // ****************************************************
    // Two-wire slave
    // ****************************************************
    i2c_state_t ist;
    logic [3:0] bitCnt;
    logic [7:0] rxShift, txShift, ptr, rdData;
    logic       isRead, nack, sdaOeReg;
    reg_wr_t    wr;
    // Start, address, pointer, write bytes, read bytes
    always_ff @(posedge clk) begin
        wr.en <= 1'b0;
        if (!rstn) begin
            ist      <= I_IDLE;
            bitCnt   <= 4'h0;
            rxShift  <= 8'h00;
            txShift  <= 8'h00;
            ptr      <= 8'h00;
            isRead   <= 1'b0;
            nack     <= 1'b0;
            sdaOeReg <= 1'b0;
            wr       <= '0;
        end else if (startCond) begin
            ist      <= I_ADDR;
            bitCnt   <= 4'h0;
            sdaOeReg <= 1'b0;
        end else if (stopCond) begin
            ist      <= I_IDLE;
            sdaOeReg <= 1'b0;
        end else if (sclRise) begin
            if (ist == I_ADDR || ist == I_REG || ist == I_WDATA) begin
                rxShift <= {rxShift[6:0], sdaS2};
                bitCnt  <= bitCnt + 4'h1;
            end
            if (ist == I_TXACK) begin
                nack <= sdaS2;
            end
        end else if (sclFall) begin
            case (ist)
                I_ADDR: if (bitCnt == 4'h8) begin
                    bitCnt <= 4'h0;
                    if (rxShift[7:1] == I2C_ADDR) begin
                        isRead   <= rxShift[0];
                        sdaOeReg <= 1'b1;
                        ist      <= I_AACK;
                    end else begin
                        ist <= I_IDLE;
                    end
                end
                I_AACK, I_TXACK: if (ist == I_AACK && !isRead) begin
                    sdaOeReg <= 1'b0;
                    ist      <= I_REG;
                end else if (ist == I_TXACK && nack) begin
                    sdaOeReg <= 1'b0;
                    ist      <= I_IDLE;
                end else begin
                    txShift  <= {rdData[6:0], 1'b0};
                    sdaOeReg <= ~rdData[7];
                    bitCnt   <= 4'h1;
                    ptr      <= ptr + 8'h01;
                    ist      <= I_TX;
                end
                I_REG: if (bitCnt == 4'h8) begin
                    bitCnt   <= 4'h0;
                    ptr      <= rxShift;
                    sdaOeReg <= 1'b1;
                    ist      <= I_RACKW;
                end
                I_RACKW, I_WACK: begin
                    sdaOeReg <= 1'b0;
                    ist      <= I_WDATA;
                end
                I_WDATA: if (bitCnt == 4'h8) begin
                    bitCnt   <= 4'h0;
                    wr       <= '{en: 1'b1, addr: ptr, data: rxShift};
                    ptr      <= ptr + 8'h01;
                    sdaOeReg <= 1'b1;
                    ist      <= I_WACK;
                end
                I_TX: if (bitCnt == 4'h8) begin
                    bitCnt   <= 4'h0;
                    sdaOeReg <= 1'b0;
                    ist      <= I_TXACK;
                end else begin
                    sdaOeReg <= ~txShift[7];
                    txShift  <= {txShift[6:0], 1'b0};
                    bitCnt   <= bitCnt + 4'h1;
                end
                default: ist <= I_IDLE;
            endcase
        end
    end
    assign sdaOe = sdaOeReg;
    // Open-drain data: only ever pulls low
    always_ff @(posedge clk) begin
        sdaOut <= 1'b0;
    end

    // ****************************************************
    // Control registers
    // ****************************************************
    logic [7:0] mode_reg, vLow_reg, vHigh_reg, gate_reg, clk_reg;
    logic [7:0] role_reg, loop_reg, stby_reg;
    logic [2:0] evt_reg, evt_next;
    wire        isLoad = wr.en && wr.addr == `OFS_MODE && wr.data[`B_LOAD];
    // Software writes; load bit is a strobe and reads zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mode_reg  <= `RST_MODE;
            vLow_reg  <= 8'(`RST_VCODE & 12'h0FF);
            vHigh_reg <= 8'(`RST_VCODE >> 8);
            gate_reg  <= `RST_ZERO;
            clk_reg   <= `RST_ZERO;
            role_reg  <= `RST_ZERO;
            loop_reg  <= `RST_ZERO;
            stby_reg  <= `RST_ZERO;
        end else if (wr.en) begin
            case (wr.addr)
                `OFS_MODE:    mode_reg  <= wr.data & 8'h1F;
                `OFS_VLOW:    vLow_reg  <= wr.data;
                `OFS_VHIGH:   vHigh_reg <= wr.data & 8'h0F;
                `OFS_GATE:    gate_reg  <= wr.data & 8'h1F;
                `OFS_CLKGATE: clk_reg   <= wr.data & 8'h01;
                `OFS_ROLE:    role_reg  <= wr.data & 8'h07;
                `OFS_LOOP:    loop_reg  <= wr.data & 8'h1F;
                `OFS_STANDBY: stby_reg  <= wr.data;
                default:      ;
            endcase
        end
    end

    // Active target changes only on the load strobe
    always_ff @(posedge clk) begin
        if (!rstn) begin
            busVoltageCode <= `RST_VCODE;
        end else if (isLoad && !mode_reg[`B_FBSEL]) begin
            busVoltageCode <= {vHigh_reg[3:0], vLow_reg};
        end
    end

    // ****************************************************
    // Mode, port and monitor decode
    // ****************************************************
    wire rev      = mode_reg[`B_REVERSE];
    wire convEn   = mode_reg[`B_CONV_EN];
    wire activity = senseS2.attached & ~stby_reg[`B_STANDBY];
    wire allowB   = role_reg[`B_PORTB_DIR] ^ rev;
    power_mode_t pmNext;
    conduction_t cmNext;
    port_set_t   gateNext;
    // Five power modes from activity, clock disable, enable
    always_comb begin
        if (!activity) begin
            pmNext = convEn ? PM_STANDBY : PM_SHUTDOWN;
        end else if (clk_reg[`B_CLKDIS]) begin
            pmNext = PM_NOCLOCK;
        end else if (!convEn) begin
            pmNext = PM_NODCDC;
        end else begin
            pmNext = PM_NORMAL;
        end
    end
    // Conduction choice, force-discontinuous first
    always_comb begin
        if (mode_reg[`B_FORCE_DISCONTINUOUS]) begin
            cmNext = CM_DCM;
        end else if (mode_reg[`B_CCM]) begin
            cmNext = CM_CCM;
        end else if (rev) begin
            cmNext = CM_PFM;
        end else begin
            cmNext = CM_AUTO;
        end
    end
    // Gate on only if enabled, direction legal, no fault
    always_comb begin
        gateNext.a  = gate_reg[`B_GATE_A] & rev & ~faultS2.a;
        gateNext.b  = gate_reg[`B_GATE_B] & allowB & ~faultS2.b;
        gateNext.c1 = gate_reg[`B_GATE_C1] & ~faultS2.c1;
        gateNext.c2 = gate_reg[`B_GATE_C2] & ~faultS2.c2;
    end
    // Registered control outputs
    always_ff @(posedge clk) begin
        if (!rstn) begin
            reverseOutputEnable  <= 1'b0;
            feedbackSourceSelect <= 1'b0;
            busCcLoopEnable      <= 1'b0;
            conductionMode       <= CM_DCM;
            portBDirection       <= 1'b0;
            typecRoleField       <= 2'b00;
            portGateDriver       <= '0;
            analogMonitorEnable  <= 1'b0;
            analogMonitorSelect  <= 4'h0;
            powerMode            <= PM_SHUTDOWN;
            converterRun         <= 1'b0;
        end else begin
            reverseOutputEnable  <= rev;
            feedbackSourceSelect <= mode_reg[`B_FBSEL];
            busCcLoopEnable      <= loop_reg[`B_CC_LOOP];
            conductionMode       <= cmNext;
            portBDirection       <= role_reg[`B_PORTB_DIR];
            typecRoleField       <= role_reg[1:0];
            portGateDriver       <= gateNext;
            analogMonitorEnable  <= gate_reg[`B_MON_EN];
            analogMonitorSelect  <= loop_reg[3:0];
            powerMode            <= pmNext;
            converterRun         <= (pmNext == PM_NORMAL);
        end
    end

    // ****************************************************
    // Core clock divider
    // ****************************************************
    logic [CW-1:0] coreCnt;
    wire coreAlive = (powerMode == PM_NODCDC) || (powerMode == PM_NORMAL);
    // Divides to nominal core rate, frozen when clock disabled
    always_ff @(posedge clk) begin
        if (!rstn) begin
            coreCnt    <= '0;
            coreClkOut <= 1'b0;
        end else if (coreAlive) begin
            coreCnt <= (coreCnt == CW'(CORE_HALF - 1)) ? '0 : coreCnt + 1'b1;
            if (coreCnt == CW'(CORE_HALF - 1)) begin
                coreClkOut <= ~coreClkOut;
            end
        end
    end

    // ****************************************************
    // Event flags, write one to clear, set wins
    // ****************************************************
    logic [2:0] evtSet;
    always_comb begin
        evtSet[0] = ~portGateDriver.a & senseScan.portALow;
        evtSet[1] = ~portBDirection & ~portGateDriver.b
                  & senseScan.portBLow;
        evtSet[2] = reverseOutputEnable & converterRun
                  & senseS2.smallCur;
        evt_next  = evt_reg;
        if (wr.en && wr.addr == `OFS_EVENT) begin
            evt_next = evt_next & ~wr.data[2:0];
        end
        evt_next = evt_next | evtSet;
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            evt_reg <= 3'h0;
        end else begin
            evt_reg <= evt_next;
        end
    end

    // Read mux for the slave
    always_comb begin
        case (ptr)
            `OFS_MODE:     rdData = mode_reg;
            `OFS_VLOW:     rdData = vLow_reg;
            `OFS_VHIGH:    rdData = vHigh_reg;
            `OFS_GATE:     rdData = gate_reg;
            `OFS_CLKGATE:  rdData = clk_reg;
            `OFS_ROLE:     rdData = role_reg;
            `OFS_LOOP:     rdData = loop_reg;
            `OFS_STANDBY:  rdData = stby_reg;
            `OFS_EVENT:    rdData = {5'h00, evt_reg};
            `OFS_PRESENCE: rdData = {1'b0, powerMode, activity,
                                     senseScan.c2Src, senseScan.c1Src,
                                     senseScan.portBSrc & portBDirection};
            default:       rdData = 8'h00;
        endcase
    end

    // ****************************************************
    // Assertions
    // ****************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    rev_mode_a: assert property (wr.en && wr.addr == `OFS_MODE
        |=> ##1 reverseOutputEnable == $past(wr.data[`B_REVERSE], 2))
        else $error("Reverse enable does not follow write");
    hold_target_a: assert property (!isLoad |=> $stable(busVoltageCode))
        else $error("Voltage target moved without load");
    load_target_a: assert property (isLoad && !mode_reg[`B_FBSEL]
        |=> busVoltageCode == {$past(vHigh_reg[3:0]), $past(vLow_reg)})
        else $error("Voltage target not loaded from pair");
    force_discontinuous_prio_a: assert property (mode_reg[`B_FORCE_DISCONTINUOUS]
        |=> conductionMode == CM_DCM)
        else $error("Force-discontinuous not obeyed");
    ccm_force_a: assert property (!mode_reg[`B_FORCE_DISCONTINUOUS] && mode_reg[`B_CCM]
        |=> conductionMode == CM_CCM)
        else $error("Continuous mode not forced");
    pfm_light_a: assert property (mode_reg[3:2] == 2'b00 && rev
        |=> conductionMode == CM_PFM)
        else $error("Light-load mode missing when discharging");
    standby_mode_a: assert property (!activity
        |=> powerMode == PM_STANDBY || powerMode == PM_SHUTDOWN)
        else $error("Active mode without activity");
    noclk_core_a: assert property (powerMode == PM_NOCLOCK
        |=> $stable(coreClkOut))
        else $error("Core clock runs while disabled");
    run_normal_a: assert property (
        converterRun == (powerMode == PM_NORMAL))
        else $error("Converter run disagrees with mode");
    gate_fault_a: assert property (faultS2.b |=> !portGateDriver.b)
        else $error("Gate left on under port fault");
    attach_flag_a: assert property (evtSet[0] |=> evt_reg[0])
        else $error("Attach event lost");
    load_cov: cover property (isLoad ##1 $changed(busVoltageCode));
    read_cov: cover property (ist == I_TX ##[1:400] ist == I_TXACK);
    attach_cov: cover property ($rose(evt_reg[0]));
    normal_cov: cover property ($rose(converterRun));
endmodule : charger_port_mode_control

// file: testbench/host_bus_model.sv
// Host controller model on the two-wire register bus
module host_bus_model #(
    parameter logic [6:0] DEV = 7'h2A // Arbitrary, same as design default
) (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sdaLow
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ackOk;
    // Bus idles released, clock parked high
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
        ackOk = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Data set in low phase, sampled just before SCL falls
    task automatic bitx(input logic v, output logic s);
        tick(1);
        sdaLow = !v;
        tick(3);
        scl = 1'b1;
        tick(4);
        s = sda;
        scl = 1'b0;
    endtask : bitx
    task automatic start;
        tick(1);
        sdaLow = 1'b0;
        tick(5);
        scl = 1'b1;
        tick(4);
        sdaLow = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask : start
    task automatic stop;
        tick(1);
        sdaLow = 1'b1;
        tick(5);
        scl = 1'b1;
        tick(4);
        sdaLow = 1'b0;
        tick(4);
    endtask : stop
    // Byte out MSB first, ninth bit is the slave answer
    task automatic sendByte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(b[i], s);
        bitx(1'b1, s);
        if (s) ackOk = 1'b0;
    endtask : sendByte
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        ackOk = 1'b1;
        start();
        sendByte({DEV, 1'b0});
        sendByte(ofs);
        sendByte(d);
        stop();
    endtask : wr
    // Pointer set, repeated start, one byte, NACK, stop
    task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
        logic s;
        start();
        sendByte({DEV, 1'b0});
        sendByte(ofs);
        start();
        sendByte({DEV, 1'b1});
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(1'b1, s);
        stop();
    endtask : rd
endmodule : host_bus_model

// file: testbench/charger_port_mode_control_tb.sv
// Self-checking bench for the port and mode control block
module charger_port_mode_control_tb;
    import charger_port_mode_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;
    logic        rstn, scl, hostLow, sda, oe, rev, fbs, ccl, dir, mEn, run, cko;
    logic        sdo;
    logic [11:0] code;
    logic [1:0]  role;
    logic [3:0]  msel;
    logic [7:0]  rdata;
    port_sense_t sense;
    port_set_t   fault, gate;
    conduction_t cm;
    power_mode_t pm;
    int          errCount = 0;
    int          testsRun = 0;
    // Open-drain wire with pull-up
    assign sda = !hostLow && (oe ? sdo : 1'b1);
    always #10 clk = ~clk;
    host_bus_model host (.clk(clk), .sda(sda), .scl(scl), .sdaLow(hostLow));
    charger_port_mode_control #(.SCAN_CYCLES(20)) dut (
        .clk(clk), .rstn(rstn), .sclIn(scl), .sdaIn(sda), .sdaOut(sdo),
        .sdaOe(oe), .senseIn(sense), .portFault(fault),
        .reverseOutputEnable(rev), .feedbackSourceSelect(fbs),
        .busVoltageCode(code), .busCcLoopEnable(ccl), .conductionMode(cm),
        .portBDirection(dir), .typecRoleField(role), .portGateDriver(gate),
        .analogMonitorEnable(mEn), .analogMonitorSelect(msel),
        .powerMode(pm), .converterRun(run), .coreClkOut(cko));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        testsRun++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.wr(a, d);
        chk(host.ackOk, 1'b1);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rdata);
        chk(rdata, e);
    endtask : rdc
    task automatic t_reset;
        chk(code, 12'h916);
        chk(cm, CM_DCM);
        chk(pm, PM_SHUTDOWN);
        rdc(8'h00, 8'h04);
        rdc(8'h07, 8'h09);
        rdc(8'h10, 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_vcode;
        wr(8'h06, 8'hFF);
        wr(8'h07, 8'h0A);
        chk(code, 12'h916);
        wr(8'h00, 8'h24);
        chk(code, 12'hAFF);
        rdc(8'h00, 8'h04);
        wr(8'h07, 8'h03);
        wr(8'h00, 8'h02);
        wr(8'h00, 8'h22);
        chk({fbs, code}, 13'h1AFF);
        $display("test vcode done");
    endtask : t_vcode
    task automatic t_mode;
        wr(8'h00, 8'h0C);
        chk(cm, CM_DCM);
        wr(8'h00, 8'h08);
        chk(cm, CM_CCM);
        wr(8'h00, 8'h01);
        chk(rev, 1'b1);
        chk(cm, CM_PFM);
        $display("test mode done");
    endtask : t_mode
    task automatic t_ports;
        wr(8'h1C, 8'h1F);
        wr(8'h28, 8'h07);
        wr(8'h2D, 8'h1A);
        chk({role, dir}, 3'b111);
        chk({ccl, mEn, msel}, 6'h1A | 6'h30);
        chk(gate, 4'b1101);
        fault = 4'b0001;
        host.tick(5);
        chk(gate, 4'b1100);
        fault = 4'h0;
        wr(8'h00, 8'h04);
        chk(gate, 4'b1110);
        fault = 4'hE;
        host.tick(5);
        chk(gate, 4'b0000);
        fault = 4'h0;
        sense = 7'b0011100;
        host.tick(60);
        wr(8'h36, 8'hFF);
        rdc(8'h36, 8'h07);
        wr(8'h28, 8'h03);
        rdc(8'h36, 8'h06);
        $display("test ports done");
    endtask : t_ports
    task automatic t_attach;
        sense = 7'b1100000;
        host.tick(60);
        rdc(8'h30, 8'h03);
        sense = 7'b0;
        host.tick(60);
        wr(8'h30, 8'h03);
        rdc(8'h30, 8'h00);
        $display("test attach done");
    endtask : t_attach
    task automatic t_power;
        logic c0;
        sense = 7'b0000001;
        host.tick(60);
        wr(8'h00, 8'h10);
        chk({pm, run}, {PM_NORMAL, 1'b1});
        chk(cm, CM_AUTO);
        c0 = cko;
        host.tick(3);
        chk(cko, !c0);
        wr(8'h27, 8'h01);
        chk(pm, PM_NOCLOCK);
        c0 = cko;
        host.tick(3);
        chk(cko, c0);
        wr(8'h27, 8'h00);
        wr(8'h2E, 8'h80);
        chk(pm, PM_STANDBY);
        wr(8'h2E, 8'h00);
        wr(8'h00, 8'h00);
        chk(pm, PM_NODCDC);
        wr(8'h00, 8'h11);
        sense = 7'b0000011;
        host.tick(60);
        rdc(8'h30, 8'h04);
        wr(8'h00, 8'h00);
        sense = 7'b0;
        host.tick(60);
        chk(pm, PM_SHUTDOWN);
        $display("test power done");
    endtask : t_power
    // Reset in mid-run returns targets, modes and flags
    task automatic t_midreset;
        rstn = 1'b0;
        host.tick(3);
        rstn = 1'b1;
        host.tick(4);
        chk(code, 12'h916);
        chk(cm, CM_DCM);
        rdc(8'h00, 8'h04);
        rdc(8'h30, 8'h00);
        $display("test midreset done");
    endtask : t_midreset
    task automatic results;
        $display("tests %0d errors %0d", testsRun, errCount);
        if (errCount == 0 && testsRun > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    // Main sequence after a 12-cycle reset
    initial begin
        rstn = 1'b0;
        sense = 7'b0;
        fault = 4'h0;
        repeat (12) @(posedge clk);
        #1 rstn = 1'b1;
        host.tick(4);
        t_reset();
        t_vcode();
        t_mode();
        t_ports();
        t_attach();
        t_power();
        t_midreset();
        results();
    end
    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        errCount++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        results();
    end
endmodule : charger_port_mode_control_tb
